// ==== spp_pkg.sv ====
package spp_pkg;

   // ****************************************************************
   // Register offsets.
   // ****************************************************************
   localparam logic [7:0] ADDR_GDT_BASE  = 8'h00;
   localparam logic [7:0] ADDR_IDT_BASE  = 8'h04;
   localparam logic [7:0] ADDR_LOCAL_SEL = 8'h08;
   localparam logic [7:0] ADDR_TASK_SEL  = 8'h0C;
   localparam logic [7:0] ADDR_CTRL      = 8'h10;
   localparam logic [7:0] ADDR_STATUS    = 8'h14;
   localparam logic [7:0] ADDR_MASK      = 8'h18;
   localparam logic [7:0] ADDR_VECTOR    = 8'h1C;

   // ****************************************************************
   // Control field positions and reset values.
   // ****************************************************************
   localparam int CTRL_LARGE_PAGE_BIT = 0;
   localparam int CTRL_ALIGN_MASK_BIT = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] PTR_RESET  = 32'h0000_0000;

   // ****************************************************************
   // Page geometry.
   // ****************************************************************
   localparam int SMALL_PAGE_BITS = 12;
   localparam int LARGE_PAGE_BITS = 22;
   localparam int DIR_LARGE_BIT   = 7;

   // ****************************************************************
   // Exception vectors.
   // ****************************************************************
   localparam logic [7:0] VEC_DIVIDE  = 8'h00;
   localparam logic [7:0] VEC_DEBUG   = 8'h01;
   localparam logic [7:0] VEC_NMI     = 8'h02;
   localparam logic [7:0] VEC_BREAK   = 8'h03;
   localparam logic [7:0] VEC_OVFL    = 8'h04;
   localparam logic [7:0] VEC_BOUNDS  = 8'h05;
   localparam logic [7:0] VEC_OPCODE  = 8'h06;
   localparam logic [7:0] VEC_NODEV   = 8'h07;
   localparam logic [7:0] VEC_DOUBLE  = 8'h08;
   localparam logic [7:0] VEC_BADTASK = 8'h0A;
   localparam logic [7:0] VEC_NOSEG   = 8'h0B;
   localparam logic [7:0] VEC_STACK   = 8'h0C;
   localparam logic [7:0] VEC_GENPROT = 8'h0D;
   localparam logic [7:0] VEC_PAGE    = 8'h0E;
   localparam logic [7:0] VEC_FPU     = 8'h10;
   localparam logic [7:0] VEC_ALIGN   = 8'h11;

   // Cause bits; the lowest index has top priority.
   localparam int CAUSE_NUM = 16;
   localparam int C_DOUBLE  = 0;
   localparam int C_NMI     = 1;
   localparam int C_DIVIDE  = 2;
   localparam int C_DEBUG   = 3;
   localparam int C_BREAK   = 4;
   localparam int C_OVFL    = 5;
   localparam int C_BOUNDS  = 6;
   localparam int C_OPCODE  = 7;
   localparam int C_NODEV   = 8;
   localparam int C_BADTASK = 9;
   localparam int C_NOSEG   = 10;
   localparam int C_STACK   = 11;
   localparam int C_GENPROT = 12;
   localparam int C_PAGE    = 13;
   localparam int C_FPU     = 14;
   localparam int C_ALIGN   = 15;

   // ****************************************************************
   // Descriptor classes.
   // ****************************************************************
   typedef enum logic [3:0] {
      DSC_DATA, DSC_CODE, DSC_TASK16, DSC_LOCAL_TABLE, DSC_CALL16,
      DSC_TASK_GATE, DSC_INT16, DSC_TRAP16, DSC_CALL32, DSC_INT32,
      DSC_TRAP32, DSC_RESERVED
   } spp_class_t;

endpackage

// ==== spp_desc_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module spp_desc_decode
   import spp_pkg::*;
(
   input  wire logic [3:0] type_code,
   input  wire logic       app_segment,
   output var spp_class_t  desc_class,
   output logic            accessed,
   output logic            writable,
   output logic            readable,
   output logic            expand_down,
   output logic            conforming,
   output logic            task_busy,
   output logic            wide32
);
   always_comb begin
      accessed    = 1'b0;
      writable    = 1'b0;
      readable    = 1'b0;
      expand_down = 1'b0;
      conforming  = 1'b0;
      task_busy   = 1'b0;
      wide32      = type_code[3];
      desc_class  = DSC_RESERVED;
      if (app_segment) begin
         accessed = type_code[0];
         if (!type_code[3]) begin
            desc_class  = DSC_DATA;
            writable    = type_code[1];
            readable    = 1'b1;
            expand_down = type_code[2];
         end else begin
            desc_class = DSC_CODE;
            readable   = type_code[1];
            conforming = type_code[2];
         end
      end else begin
         case (type_code)
            4'h1, 4'h3, 4'h9, 4'hB: begin
               desc_class = DSC_TASK16;
               task_busy  = type_code[1];
            end
            4'h2: desc_class = DSC_LOCAL_TABLE;
            4'h4: desc_class = DSC_CALL16;
            4'h5: desc_class = DSC_TASK_GATE;
            4'h6: desc_class = DSC_INT16;
            4'h7: desc_class = DSC_TRAP16;
            4'hC: desc_class = DSC_CALL32;
            4'hE: desc_class = DSC_INT32;
            4'hF: desc_class = DSC_TRAP32;
            default: desc_class = DSC_RESERVED;
         endcase
      end
   end
endmodule // spp_desc_decode
`default_nettype wire

// ==== spp_vector_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
module spp_vector_sel
   import spp_pkg::*;
(
   input  wire logic [CAUSE_NUM-1:0] causes,
   output logic                      any,
   output logic [7:0]                vector
);
   function automatic logic [7:0] cause_vec(input int idx);
      case (idx)
         C_DOUBLE:  cause_vec = VEC_DOUBLE;
         C_NMI:     cause_vec = VEC_NMI;
         C_DIVIDE:  cause_vec = VEC_DIVIDE;
         C_DEBUG:   cause_vec = VEC_DEBUG;
         C_BREAK:   cause_vec = VEC_BREAK;
         C_OVFL:    cause_vec = VEC_OVFL;
         C_BOUNDS:  cause_vec = VEC_BOUNDS;
         C_OPCODE:  cause_vec = VEC_OPCODE;
         C_NODEV:   cause_vec = VEC_NODEV;
         C_BADTASK: cause_vec = VEC_BADTASK;
         C_NOSEG:   cause_vec = VEC_NOSEG;
         C_STACK:   cause_vec = VEC_STACK;
         C_GENPROT: cause_vec = VEC_GENPROT;
         C_PAGE:    cause_vec = VEC_PAGE;
         C_FPU:     cause_vec = VEC_FPU;
         C_ALIGN:   cause_vec = VEC_ALIGN;
         default:   cause_vec = VEC_GENPROT;
      endcase
   endfunction

   // Scanning downward lets the lowest index win.
   always_comb begin
      any    = |causes;
      vector = 8'h00;
      for (int i = CAUSE_NUM - 1; i >= 0; i--) begin
         if (causes[i]) begin
            vector = cause_vec(i);
         end
      end
   end
endmodule // spp_vector_sel
`default_nettype wire

// ==== spp_protect.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Holds global and interrupt table bases, local table and task pointers.
// - Physical addresses produced are 32 bits wide, four gigabytes.
// - Small and large pages coexist in one directory.
// - Large page enable plus directory flag selects large page, else small.
// - Application types 0 to 7 decode as data with accessed, write, down.
// - Application types 8 to F decode as code with accessed, read, conform.
// - System types decode task blocks and local table; 0,8,A,D reserved.
// - Gate types decode call, task, interrupt and trap gates.
// - Divide by zero raises vector 0.
// - Sampled nonmaskable interrupt raises vector 2.
// - Fault during fault handling raises vector 8.
// - Task switch to invalid task block raises vector 10.
// - Loading a not-present segment raises vector 11.
// - Stack limit or not-present stack segment raises vector 12.
// - General protection 13; others use vectors 1,3,4,5,6,7,16.
// - Page protection fault or missing page raises vector 14.
// - Unaligned reference raises 17 only with flag and mask bit set.
module spp_protect
   import spp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic             irq,
   input  wire logic [31:0] lin_addr,
   input  wire logic [31:0] directory_entry,
   input  wire logic [31:0] table_entry,
   input  wire logic        xlate_req,
   output logic             xlate_valid,
   output logic             xlate_large,
   output logic [31:0]      phys_addr,
   input  wire logic [3:0]  desc_type,
   input  wire logic        desc_app,
   output var spp_class_t   desc_class_q,
   output logic [5:0]       desc_flags_q,
   output logic             desc_wide_q,
   input  wire logic        nonmaskable_irq_line,
   input  wire logic        divide_zero,
   input  wire logic        debug_event,
   input  wire logic        breakpoint_instr,
   input  wire logic        overflow_trap_instr,
   input  wire logic        bounds_fail,
   input  wire logic        invalid_opcode,
   input  wire logic        device_absent,
   input  wire logic        fault_in_handler,
   input  wire logic        bad_task_switch,
   input  wire logic        segment_absent,
   input  wire logic        stack_fault,
   input  wire logic        general_fault,
   input  wire logic        page_fault,
   input  wire logic        float_error,
   input  wire logic        unaligned_ref,
   input  wire logic        alignment_check_flag,
   input  wire logic        soft_int,
   input  wire logic [7:0]  soft_vector,
   output logic             vec_valid,
   output logic [7:0]       vec_num
);

   // ****************************************************************
   // Descriptor table and task pointers.
   // ****************************************************************
   logic [31:0] gdt_base_q;
   logic [31:0] idt_base_q;
   logic [31:0] local_ptr_q;
   logic [31:0] task_ptr_q;
   logic [31:0] control_reg_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gdt_base_q <= PTR_RESET;
         idt_base_q <= PTR_RESET;
         local_ptr_q <= PTR_RESET;
         task_ptr_q <= PTR_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_GDT_BASE: gdt_base_q <= reg_wdata;
            ADDR_IDT_BASE: idt_base_q <= reg_wdata;
            ADDR_LOCAL_SEL: local_ptr_q <= reg_wdata;
            ADDR_TASK_SEL: task_ptr_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Bit 0 acts as control_reg_four's large_page_enable, bit 1 as
   // control_reg_zero's alignment_mask_bit.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         control_reg_q <= CTRL_RESET;
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         control_reg_q <= reg_wdata;
      end
   end

   logic large_page_enable;
   logic alignment_mask_bit;
   assign large_page_enable  = control_reg_q[CTRL_LARGE_PAGE_BIT];
   assign alignment_mask_bit = control_reg_q[CTRL_ALIGN_MASK_BIT];

   // ****************************************************************
   // Page translation.
   // ****************************************************************
   logic directory_large_page_flag;
   logic use_large;
   assign directory_large_page_flag = directory_entry[DIR_LARGE_BIT];
   // Both page sizes may come from the same directory per entry.
   assign use_large = large_page_enable
                      && directory_large_page_flag;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xlate_valid <= 1'b0;
         xlate_large <= 1'b0;
         phys_addr   <= 32'h0000_0000;
      end else begin
         xlate_valid <= xlate_req;
         if (xlate_req) begin
            xlate_large <= use_large;
            if (use_large) begin
               phys_addr <= {directory_entry[31:LARGE_PAGE_BITS],
                             lin_addr[LARGE_PAGE_BITS-1:0]};
            end else begin
               phys_addr <= {table_entry[31:SMALL_PAGE_BITS],
                             lin_addr[SMALL_PAGE_BITS-1:0]};
            end
         end
      end
   end

   // ****************************************************************
   // Descriptor type decode.
   // ****************************************************************
   spp_class_t desc_class_c;
   logic [5:0] desc_flags_c;
   logic       desc_wide_c;

   spp_desc_decode u_desc (
      .type_code   (desc_type),
      .app_segment (desc_app),
      .desc_class  (desc_class_c),
      .accessed    (desc_flags_c[0]),
      .writable    (desc_flags_c[1]),
      .readable    (desc_flags_c[2]),
      .expand_down (desc_flags_c[3]),
      .conforming  (desc_flags_c[4]),
      .task_busy   (desc_flags_c[5]),
      .wide32      (desc_wide_c)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         desc_class_q <= DSC_RESERVED;
         desc_flags_q <= 6'h00;
         desc_wide_q  <= 1'b0;
      end else begin
         desc_class_q <= desc_class_c;
         desc_flags_q <= desc_flags_c;
         desc_wide_q  <= desc_wide_c;
      end
   end

   // ****************************************************************
   // Exception causes.
   // ****************************************************************
   // The nonmaskable line is a pin, so it is synchronised first.
   logic nmi_meta_q;
   logic nmi_sync_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nmi_meta_q <= 1'b0;
         nmi_sync_q <= 1'b0;
      end else begin
         nmi_meta_q <= nonmaskable_irq_line;
         nmi_sync_q <= nmi_meta_q;
      end
   end

   logic [CAUSE_NUM-1:0] causes;
   always_comb begin
      causes            = '0;
      causes[C_DOUBLE]  = fault_in_handler;
      causes[C_NMI]     = nmi_sync_q;
      causes[C_DIVIDE]  = divide_zero;
      causes[C_DEBUG]   = debug_event;
      causes[C_BREAK]   = breakpoint_instr;
      causes[C_OVFL]    = overflow_trap_instr;
      causes[C_BOUNDS]  = bounds_fail;
      causes[C_OPCODE]  = invalid_opcode;
      causes[C_NODEV]   = device_absent;
      causes[C_BADTASK] = bad_task_switch;
      causes[C_NOSEG]   = segment_absent;
      causes[C_STACK]   = stack_fault;
      causes[C_GENPROT] = general_fault;
      causes[C_PAGE]    = page_fault;
      causes[C_FPU]     = float_error;
      // Unaligned data is legal unless both enables are on.
      causes[C_ALIGN]   = unaligned_ref && alignment_check_flag
                          && alignment_mask_bit;
   end

   logic       hw_any;
   logic [7:0] hw_vec;

   spp_vector_sel u_vec (
      .causes (causes),
      .any    (hw_any),
      .vector (hw_vec)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         vec_valid <= 1'b0;
         vec_num   <= 8'h00;
      end else begin
         vec_valid <= hw_any || soft_int;
         if (hw_any) begin
            vec_num <= hw_vec;
         end else if (soft_int) begin
            vec_num <= soft_vector;
         end
      end
   end

   // ****************************************************************
   // Interrupt status and mask.
   // ****************************************************************
   logic [CAUSE_NUM-1:0] status_q;
   logic [CAUSE_NUM-1:0] mask_q;
   logic                 status_rd;
   assign status_rd = reg_rd && reg_addr == ADDR_STATUS;

   // A cause arriving in the clearing read's cycle stays set.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= '0;
      end else begin
         status_q <= (status_rd ? '0 : status_q) | causes;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mask_q <= '0;
      end else if (reg_wr && reg_addr == ADDR_MASK) begin
         mask_q <= reg_wdata[CAUSE_NUM-1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((status_rd ? '0 : status_q) | causes) & mask_q);
      end
   end

   // ****************************************************************
   // Register read port.
   // ****************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_GDT_BASE: reg_rdata <= gdt_base_q;
            ADDR_IDT_BASE: reg_rdata <= idt_base_q;
            ADDR_LOCAL_SEL: reg_rdata <= local_ptr_q;
            ADDR_TASK_SEL: reg_rdata <= task_ptr_q;
            ADDR_CTRL:     reg_rdata <= control_reg_q;
            ADDR_STATUS:   reg_rdata <= {16'h0000, status_q};
            ADDR_MASK:     reg_rdata <= {16'h0000, mask_q};
            ADDR_VECTOR:   reg_rdata <= {24'h00_0000, vec_num};
            default:       reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule // spp_protect
`default_nettype wire

// ==== spp_protect_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module spp_protect_sva
   import spp_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic [31:0] lin_addr,
   input wire logic [31:0] directory_entry,
   input wire logic [31:0] table_entry,
   input wire logic        xlate_req,
   input wire logic        xlate_valid,
   input wire logic        xlate_large,
   input wire logic [31:0] phys_addr,
   input wire logic [3:0]  desc_type,
   input wire logic        desc_app,
   input var  spp_class_t  desc_class_q,
   input wire logic [5:0]  desc_flags_q,
   input wire logic        nonmaskable_irq_line,
   input wire logic        divide_zero,
   input wire logic        fault_in_handler,
   input wire logic        unaligned_ref,
   input wire logic        alignment_check_flag,
   input wire logic        soft_int,
   input wire logic        vec_valid,
   input wire logic [7:0]  vec_num
);
   // ********
   // Shadow state.
   // ********
   // Control bits are shadowed from writes.
   logic [1:0] ctrl_q;
   logic [1:0] live_q;
   logic [2:0] nmi_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= 2'h0;
         live_q <= 2'h0;
         nmi_q  <= 3'h0;
      end else begin
         live_q <= {live_q[0], 1'b1};
         nmi_q  <= {nmi_q[1:0], nonmaskable_irq_line};
         if (reg_wr && reg_addr == ADDR_CTRL) begin
            ctrl_q <= reg_wdata[1:0];
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_xlate_answer: assert property (
      xlate_req && live_q[1] |=> xlate_valid)
      else $error("translation answer missing");
   chk_large_page: assert property (
      xlate_req && live_q[1] && ctrl_q[0] && directory_entry[DIR_LARGE_BIT]
      |=> xlate_large && phys_addr == {$past(directory_entry[31:22]),
      $past(lin_addr[21:0])})
      else $error("large page translation wrong");
   chk_small_page: assert property (
      xlate_req && live_q[1] && !(ctrl_q[0] && directory_entry[DIR_LARGE_BIT])
      |=> !xlate_large && phys_addr == {$past(table_entry[31:12]),
      $past(lin_addr[11:0])})
      else $error("small page translation wrong");
   chk_data_decode: assert property (
      desc_app && !desc_type[3] && live_q[1] |=> desc_class_q == DSC_DATA
      && {desc_flags_q[3], desc_flags_q[1:0]} == $past(desc_type[2:0]))
      else $error("data descriptor decode wrong");
   chk_code_decode: assert property (
      desc_app && desc_type[3] && live_q[1] |=> desc_class_q == DSC_CODE
      && {desc_flags_q[4], desc_flags_q[2], desc_flags_q[0]}
      == $past(desc_type[2:0]))
      else $error("code descriptor decode wrong");
   chk_double_vec: assert property (
      fault_in_handler && live_q[1] |=> vec_valid && vec_num == VEC_DOUBLE)
      else $error("double fault vector wrong");
   chk_nmi_vec: assert property (
      (nonmaskable_irq_line && live_q[1] ##2 !fault_in_handler)
      |=> vec_valid && vec_num == VEC_NMI)
      else $error("nonmaskable vector wrong");
   chk_divide_vec: assert property (
      divide_zero && !fault_in_handler && nmi_q == 3'h0 && live_q[1]
      |=> vec_valid && vec_num == VEC_DIVIDE)
      else $error("divide vector wrong");
   chk_align_gate: assert property (
      vec_valid && vec_num == VEC_ALIGN && !$past(soft_int)
      |-> $past(unaligned_ref && alignment_check_flag && ctrl_q[1]))
      else $error("alignment vector without enables");
endmodule // spp_protect_sva

bind spp_protect spp_protect_sva u_sva (
   .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .lin_addr,
   .directory_entry, .table_entry, .xlate_req, .xlate_valid,
   .xlate_large, .phys_addr, .desc_type, .desc_app, .desc_class_q,
   .desc_flags_q, .nonmaskable_irq_line, .divide_zero, .fault_in_handler,
   .unaligned_ref, .alignment_check_flag, .soft_int, .vec_valid, .vec_num
);
`default_nettype wire

// ==== spp_pipe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// Pipeline stand-in: raises causes for one cycle, counts vectors.
// ********
module spp_pipe_model
   import spp_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic [CAUSE_NUM-1:0] raise,
   input  wire logic                 vec_valid,
   input  wire logic [7:0]           vec_num,
   output logic      [CAUSE_NUM-1:0] cause,
   output logic      [7:0]           last_vec,
   output logic      [7:0]           vec_count
);
   // Registered, so causes change just after an edge.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cause     <= '0;
         last_vec  <= 8'h00;
         vec_count <= 8'h00;
      end else begin
         cause <= raise;
         if (vec_valid) begin
            last_vec  <= vec_num;
            vec_count <= vec_count + 8'h01;
         end
      end
   end
endmodule // spp_pipe_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   import spp_pkg::*;
   logic                 clk, nrst, reg_wr, reg_rd, irq, xlate_req;
   logic                 xlate_valid, xlate_large, desc_app, desc_wide_q;
   logic                 soft_int, alignment_check_flag, vec_valid;
   logic [7:0]           reg_addr, soft_vector, vec_num, last_vec, vec_count;
   logic [31:0]          reg_wdata, reg_rdata, lin_addr, phys_addr;
   logic [31:0]          directory_entry, table_entry, d, p [4];
   logic [3:0]           desc_type;
   logic [5:0]           desc_flags_q;
   logic [CAUSE_NUM-1:0] raise, cause, m;
   spp_class_t           desc_class_q;
   int                   fails, compares;
   logic [7:0]           vtab [16] = '{8'h08, 8'h02, 8'h00, 8'h01, 8'h03,
      8'h04, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10,
      8'h11};

   spp_protect uut (
      .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
      .lin_addr, .directory_entry, .table_entry, .xlate_req, .xlate_valid,
      .xlate_large, .phys_addr, .desc_type, .desc_app, .desc_class_q,
      .desc_flags_q, .desc_wide_q, .alignment_check_flag, .soft_int,
      .soft_vector, .vec_valid, .vec_num,
      .nonmaskable_irq_line(cause[C_NMI]), .divide_zero(cause[C_DIVIDE]),
      .debug_event(cause[C_DEBUG]), .breakpoint_instr(cause[C_BREAK]),
      .overflow_trap_instr(cause[C_OVFL]), .bounds_fail(cause[C_BOUNDS]),
      .invalid_opcode(cause[C_OPCODE]), .device_absent(cause[C_NODEV]),
      .fault_in_handler(cause[C_DOUBLE]), .bad_task_switch(cause[C_BADTASK]),
      .segment_absent(cause[C_NOSEG]), .stack_fault(cause[C_STACK]),
      .general_fault(cause[C_GENPROT]), .page_fault(cause[C_PAGE]),
      .float_error(cause[C_FPU]), .unaligned_ref(cause[C_ALIGN]));
   spp_pipe_model u_pipe (.clk, .nrst, .raise, .vec_valid, .vec_num, .cause,
      .last_vec, .vec_count);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ********
   // Shared tasks.
   // ********
   task automatic check(input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      @(posedge clk);
   endtask

   // Read data stand one cycle after the strobe.
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 check(reg_rdata, e);
      @(posedge clk);
   endtask

   task automatic xlate(input logic lpe);
      logic [31:0] l, dr, t;
      logic        big;
      l = $urandom;
      dr = $urandom;
      t = $urandom;
      big = lpe && dr[7];
      wr(ADDR_CTRL, 32'(lpe));
      lin_addr <= l;
      directory_entry <= dr;
      table_entry <= t;
      xlate_req <= 1'b1;
      @(posedge clk);
      xlate_req <= 1'b0;
      #1 check(xlate_valid, 1);
      check(xlate_large, big);
      check(phys_addr, big ? {dr[31:22],l[21:0]} : {t[31:12],l[11:0]});
      @(posedge clk);
   endtask

   // Bounded wait; the vector may never come.
   task automatic fire(input logic [CAUSE_NUM-1:0] c, input logic want,
                       input logic [7:0] e);
      logic [7:0] n0;
      n0 = vec_count;
      raise <= c;
      @(posedge clk);
      raise <= '0;
      for (int k = 0; k < 8 && vec_count == n0; k++) @(posedge clk);
      check(vec_count, n0 + {7'h00, want});
      if (want) check(last_vec, e);
      repeat (4) @(posedge clk);
   endtask

   function automatic spp_class_t exp_class(input logic [4:0] i);
      if (i[4]) return i[3] ? DSC_CODE : DSC_DATA;
      case (i[3:0])
         4'h1, 4'h3, 4'h9, 4'hB: return DSC_TASK16;
         4'h2: return DSC_LOCAL_TABLE;
         4'h4: return DSC_CALL16;
         4'h5: return DSC_TASK_GATE;
         4'h6: return DSC_INT16;
         4'h7: return DSC_TRAP16;
         4'hC: return DSC_CALL32;
         4'hE: return DSC_INT32;
         4'hF: return DSC_TRAP32;
         default: return DSC_RESERVED;
      endcase
   endfunction

   function automatic logic [7:0] exp_pick(input logic [CAUSE_NUM-1:0] c);
      for (int i = 0; i < CAUSE_NUM; i++) if (c[i]) return vtab[i];
      return 8'h00;
   endfunction

   task automatic end_sim;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ********
   // Main sequence.
   // ********
   initial begin
      {nrst, reg_wr, reg_rd, xlate_req, desc_app, soft_int} = '0;
      {reg_addr, soft_vector, desc_type, alignment_check_flag} = '0;
      {reg_wdata, lin_addr, directory_entry, table_entry, raise} = '0;
      void'($urandom(44));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 9; i++) rchk(8'(i * 4), 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         p[i] = $urandom;
         wr(8'(i * 4), p[i]);
      end
      for (int i = 0; i < 4; i++) rchk(8'(i * 4), p[i]);
      for (int i = 0; i < 24; i++) xlate(1'($urandom));
      for (int i = 0; i < 32; i++) begin
         desc_app  <= i[4];
         desc_type <= i[3:0];
         @(posedge clk);
         #1 check(desc_class_q, exp_class(i[4:0]));
         check(desc_wide_q, i[3]);
         check(desc_flags_q[5], !i[4] && i[2:0] == 3'h3);
         @(posedge clk);
      end
      wr(ADDR_CTRL, 32'h0000_0002);
      alignment_check_flag <= 1'b1;
      for (int i = 0; i < CAUSE_NUM; i++) fire(1 << i, 1, vtab[i]);
      for (int i = 0; i < 20; i++) begin
         m = $urandom;
         m[C_NMI] = 1'b0;
         fire(m, m != '0, exp_pick(m));
      end
      alignment_check_flag <= 1'b0;
      fire(1 << C_ALIGN, 0, 8'h00);
      alignment_check_flag <= 1'b1;
      wr(ADDR_CTRL, 32'h0000_0000);
      fire(1 << C_ALIGN, 0, 8'h00);
      for (int i = 0; i < 3; i++) begin
         d = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'h0000_00FF : $urandom;
         soft_vector <= d[7:0];
         soft_int <= 1'b1;
         @(posedge clk);
         soft_int <= 1'b0;
         #1 check(vec_num, d[7:0]);
         @(posedge clk);
      end
      rchk(ADDR_STATUS, 32'h0000_FFFF);
      wr(ADDR_MASK, 32'h0000_0000);
      fire(1 << C_PAGE, 1, 8'h0E);
      check(irq, 0);
      rchk(ADDR_STATUS, 32'h0000_2000);
      rchk(ADDR_STATUS, 32'h0000_0000);
      wr(ADDR_MASK, 32'h0000_2000);
      fire(1 << C_PAGE, 1, 8'h0E);
      check(irq, 1);
      rchk(ADDR_VECTOR, 32'h0000_000E);
      rchk(ADDR_STATUS, 32'h0000_2000);
      repeat (2) @(posedge clk);
      check(irq, 0);
      end_sim;
   end
endmodule // tb
`default_nettype wire
